//--- hw/stp_pkg.sv
// Overview of operation
// - First jog input moves counterclockwise, second jog input moves clockwise.
// - Jog-rate select picks which of two stored jog velocities applies.
// - Both jog velocities set by serial command and kept in non-volatile storage.
// - Jog step rate ramps by programmable acceleration, avoiding stall; zero acceleration jumps straight to target.
// - Counterclockwise limit blocks counterclockwise motion, clockwise still allowed.
// - Clockwise limit blocks clockwise motion, counterclockwise still allowed.
// - Low disable input switches the output power drivers off.
// - Controller gives one step pulse per step; device advances one step each.
// - After power-up, before any step, hold current level is selected.
// - A step pulse raises the winding current command to run level.
// - After the last step edge current drops to hold: 0, 15, 50, 100 percent.
// - Full, half, quarter and eighth step resolution chosen by microstep select.
// - Encoder option reuses step and direction pins as quadrature A and B.
// - Encoder option decodes quadrature into internal step and direction exactly.
// - Every edge of both channels counts, four steps per encoder slot.
// - Slow decay at low speed, fast decay at high speed, from measured rate.
// - Two-wire serial port, one receive and one transmit line, for commands.
// - Stored parameters are kept after the serial adapter is disconnected.
package stp_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MAX_RATE_SPS = 40_000;
  localparam int unsigned STEP_PW_US = 12;
  localparam int unsigned STEP_PW_CYC = (STEP_PW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_DLY_MS = 100;
  localparam int unsigned HOLD_DLY_CYC = HOLD_DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned RAMP_TICK_US = 1000;
  localparam int unsigned RAMP_TICK_CYC = RAMP_TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DECAY_WIN_MS = 10;
  localparam int unsigned DECAY_WIN_CYC = DECAY_WIN_MS * (CLK_HZ / 1000);
  localparam int unsigned UART_BAUD = 9600;
  localparam int unsigned UART_BIT_CYC = CLK_HZ / UART_BAUD;
  // ****************************************
  // widths and values
  // ****************************************
  localparam int ACC_W = 26;
  localparam int RATE_W = 16;
  localparam int POS_W = 5;
  localparam int PCT_W = 7;
  localparam int CNT_W = 24;
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_HZ);
  localparam logic [RATE_W-1:0] RATE_MAX = RATE_W'(MAX_RATE_SPS);
  localparam logic [PCT_W-1:0] RUN_PCT = 7'h64;
  localparam logic [PCT_W-1:0] HOLD_PCT_0 = 7'h00;
  localparam logic [PCT_W-1:0] HOLD_PCT_1 = 7'h0F;
  localparam logic [PCT_W-1:0] HOLD_PCT_2 = 7'h32;
  localparam logic [PCT_W-1:0] HOLD_PCT_3 = 7'h64;
  localparam logic [POS_W-1:0] FULL_STEP_UNITS = 5'h08;
  // ****************************************
  // serial commands
  // ****************************************
  localparam logic [7:0] CMD_JOG = 8'h42;
  localparam logic [7:0] CMD_DECAY = 8'h62;
  localparam logic [7:0] CMD_ACCEL = 8'h4B;
  localparam logic [7:0] CMD_STORE = 8'h53;
  localparam logic [7:0] CMD_CLEAR = 8'h43;
  localparam logic [7:0] NAK_BYTE = 8'h3F;
  localparam logic [2:0] LEN_BAD = 3'h7;
  localparam logic [2:0] LEN_JOG = 3'h4;
  localparam logic [2:0] LEN_WORD = 3'h2;
  localparam logic [2:0] LEN_NONE = 3'h0;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [RATE_W-1:0] jog_slow;
    logic [RATE_W-1:0] jog_fast;
    logic [RATE_W-1:0] accel;
    logic [RATE_W-1:0] decay_thr;
  } stp_params_t;
  localparam stp_params_t PARAMS_DEFAULT = '{16'h03E8, 16'h1388, 16'h0064, 16'h0032};
  typedef struct packed {
    logic step;
    logic dir;
    logic jog_ccw;
    logic jog_cw;
    logic jog_rate;
    logic lim_ccw;
    logic lim_cw;
    logic disable_n;
    logic rxd;
  } stp_pins_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                            RX_STOP = 2'b11} stp_rx_st_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} stp_tx_st_t;
  typedef enum logic {CMD_WAIT = 1'b0, CMD_PAY = 1'b1} stp_cmd_st_t;
  // standstill percentage for each select code
  function automatic logic [PCT_W-1:0] hold_pct(input logic [1:0] sel);
    case (sel)
      2'h0: hold_pct = HOLD_PCT_0;
      2'h1: hold_pct = HOLD_PCT_1;
      2'h2: hold_pct = HOLD_PCT_2;
      default: hold_pct = HOLD_PCT_3;
    endcase
  endfunction
  // payload byte count of a command byte
  function automatic logic [2:0] cmd_len(input logic [7:0] cmd);
    case (cmd)
      CMD_JOG: cmd_len = LEN_JOG;
      CMD_ACCEL: cmd_len = LEN_WORD;
      CMD_DECAY: cmd_len = LEN_WORD;
      CMD_STORE: cmd_len = LEN_NONE;
      CMD_CLEAR: cmd_len = LEN_NONE;
      default: cmd_len = LEN_BAD;
    endcase
  endfunction
endpackage

//--- hw/stp_sync.sv
`timescale 1ns/100ps
module stp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [W-1:0] d_i, // asynchronous levels
  output logic [W-1:0] q_o // synchronised levels
);
  // ****************************************
  // two-stage synchroniser per bit
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= d_i[i];
        sync_q <= meta_q;
      end
    end
    assign q_o[i] = sync_q;
  end
endmodule

//--- hw/stp_ctrl.sv
`timescale 1ns/100ps
module stp_ctrl #(
  parameter int unsigned HOLD_CYC = stp_pkg::HOLD_DLY_CYC, // standstill delay
  parameter int unsigned TICK_CYC = stp_pkg::RAMP_TICK_CYC, // ramp update period
  parameter int unsigned WIN_CYC = stp_pkg::DECAY_WIN_CYC, // rate gate window
  parameter int unsigned BIT_CYC = stp_pkg::UART_BIT_CYC // serial bit time
) (
  input wire logic SYS_CLK_I, // system clock
  input wire logic RST_N_I, // synchronous reset, active low
  input wire logic STEP_I, // step clock, or channel a
  input wire logic DIR_I, // direction, high cw, or channel b
  input wire logic ENC_MODE_I, // high selects encoder following
  input wire logic JOG_CCW_I, // jog counterclockwise
  input wire logic JOG_CW_I, // jog clockwise
  input wire logic JOG_RATE_SELECT_I, // high picks fast jog speed
  input wire logic LIM_CCW_I, // blocks ccw motion
  input wire logic LIM_CW_I, // blocks cw motion
  input wire logic DISABLE_N_I, // low turns power drivers off
  input wire logic [1:0] MICROSTEP_SELECT_I, // 0 full .. 3 eighth
  input wire logic [1:0] STANDSTILL_CURRENT_SELECT_I, // hold level code
  input wire logic RXD_I, // serial receive
  input wire stp_pkg::stp_params_t NV_DATA_I, // stored parameters
  output logic STEP_O, // step pulse to phase sequencer
  output logic DIR_O, // direction of last step, high cw
  output logic [stp_pkg::POS_W-1:0] POS_O, // microstep phase index
  output logic RUN_CUR_O, // high while at run current
  output logic [stp_pkg::PCT_W-1:0] CUR_PCT_O, // current command, percent
  output logic DECAY_CHOICE_O, // high selects fast decay
  output logic DRV_EN_O, // power driver enable
  output logic TXD_O, // serial transmit
  output logic NV_WR_O, // store pulse to nv memory
  output stp_pkg::stp_params_t NV_DATA_O // working parameters
);
  import stp_pkg::*;

  // ****************************************
  // input synchronisation
  // ****************************************
  stp_pins_t pins_raw;
  stp_pins_t s;
  assign pins_raw = {STEP_I, DIR_I, JOG_CCW_I, JOG_CW_I, JOG_RATE_SELECT_I, LIM_CCW_I,
                     LIM_CW_I, DISABLE_N_I, RXD_I};
  stp_sync #(.W($bits(stp_pins_t))) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(pins_raw),
    .q_o(s)
  );

  // ****************************************
  // external step and quadrature decode
  // ****************************************
  logic a_prev_q, b_prev_q, ext_ev, ext_cw;
  // step edge, or any single-channel quadrature edge
  always_comb begin
    ext_ev = 1'b0;
    ext_cw = s.dir;
    if (ENC_MODE_I) begin
      ext_ev = (s.step ^ a_prev_q) ^ (s.dir ^ b_prev_q);
      ext_cw = a_prev_q ^ s.dir;
    end else begin
      ext_ev = s.step & ~a_prev_q;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= s.step;
      b_prev_q <= s.dir;
    end
  end

  // ****************************************
  // jog ramp and rate generator
  // ****************************************
  stp_params_t params_q, params_d;
  logic [RATE_W-1:0] rate_q, rate_d, target, speed;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [ACC_W:0] sum;
  logic [CNT_W-1:0] tick_q, tick_d;
  logic mdir_q, mdir_d, ccw_ok, cw_ok, want, tick_end, jog_ev;
  // target follows jog inputs, rate moves toward it by accel each tick
  always_comb begin
    ccw_ok = s.jog_ccw & ~s.jog_cw & ~s.lim_ccw;
    cw_ok = s.jog_cw & ~s.jog_ccw & ~s.lim_cw;
    speed = s.jog_rate ? params_q.jog_fast : params_q.jog_slow;
    if (speed > RATE_MAX) speed = RATE_MAX;
    mdir_d = mdir_q;
    if (rate_q == '0) mdir_d = cw_ok ? 1'b1 : (ccw_ok ? 1'b0 : mdir_q);
    want = mdir_d ? cw_ok : ccw_ok;
    target = want ? speed : '0;
    tick_end = (tick_q == CNT_W'(TICK_CYC - 1));
    tick_d = tick_end ? '0 : tick_q + 1'b1;
    rate_d = rate_q;
    if (tick_end) begin
      if (params_q.accel == '0) rate_d = target;
      else if (rate_q < target)
        rate_d = (target - rate_q > params_q.accel) ? rate_q + params_q.accel : target;
      else if (rate_q > target)
        rate_d = (rate_q - target > params_q.accel) ? rate_q - params_q.accel : target;
    end
    sum = {1'b0, acc_q} + (ACC_W + 1)'(rate_q);
    jog_ev = 1'b0;
    acc_d = '0;
    if (rate_q != '0) begin
      if (sum >= {1'b0, ACC_WRAP}) begin
        jog_ev = 1'b1;
        acc_d = ACC_W'(sum - {1'b0, ACC_WRAP});
      end else begin
        acc_d = sum[ACC_W-1:0];
      end
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      rate_q <= '0;
      acc_q <= '0;
      tick_q <= '0;
      mdir_q <= 1'b0;
    end else begin
      rate_q <= rate_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
      mdir_q <= mdir_d;
    end
  end

  // ****************************************
  // step output, limits and position
  // ****************************************
  logic fire_cw, step_fire, step_q, step_d, dir_q, dir_d;
  logic [POS_W-1:0] pos_q, pos_d, inc;
  logic [CNT_W-1:0] pw_q, pw_d;
  // external steps win a tie with jog steps
  always_comb begin
    fire_cw = ext_ev ? ext_cw : mdir_q;
    step_fire = (ext_ev | jog_ev) & ~(fire_cw ? s.lim_cw : s.lim_ccw);
    inc = FULL_STEP_UNITS >> MICROSTEP_SELECT_I;
    step_d = step_q;
    dir_d = dir_q;
    pos_d = pos_q;
    pw_d = pw_q;
    if (step_fire) begin
      step_d = 1'b1;
      dir_d = fire_cw;
      pw_d = CNT_W'(STEP_PW_CYC - 1);
      pos_d = fire_cw ? pos_q + inc : pos_q - inc;
    end else if (pw_q != '0) begin
      pw_d = pw_q - 1'b1;
    end else begin
      step_d = 1'b0;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
      pos_q <= '0;
      pw_q <= '0;
    end else begin
      step_q <= step_d;
      dir_q <= dir_d;
      pos_q <= pos_d;
      pw_q <= pw_d;
    end
  end
  assign STEP_O = step_q;
  assign DIR_O = dir_q;
  assign POS_O = pos_q;

  // ****************************************
  // run and hold current, decay, enable
  // ****************************************
  logic run_q, run_d, fast_q, fast_d, en_q;
  logic [PCT_W-1:0] pct_q, pct_d;
  logic [CNT_W-1:0] idle_q, idle_d, win_q, win_d;
  logic [RATE_W-1:0] cnt_q, cnt_d;
  // run on any step, hold after a quiet delay; decay from steps per window
  always_comb begin
    run_d = run_q;
    idle_d = '0;
    if (step_fire) run_d = 1'b1;
    else if (run_q) begin
      if (idle_q == CNT_W'(HOLD_CYC - 1)) run_d = 1'b0;
      else idle_d = idle_q + 1'b1;
    end
    pct_d = run_d ? RUN_PCT : hold_pct(STANDSTILL_CURRENT_SELECT_I);
    fast_d = fast_q;
    cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + RATE_W'(step_fire);
    win_d = win_q + 1'b1;
    if (win_q == CNT_W'(WIN_CYC - 1)) begin
      fast_d = (params_q.decay_thr != '0) && (cnt_q >= params_q.decay_thr);
      cnt_d = RATE_W'(step_fire);
      win_d = '0;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      run_q <= 1'b0;
      idle_q <= '0;
      pct_q <= HOLD_PCT_0;
      fast_q <= 1'b0;
      cnt_q <= '0;
      win_q <= '0;
      en_q <= 1'b0;
    end else begin
      run_q <= run_d;
      idle_q <= idle_d;
      pct_q <= pct_d;
      fast_q <= fast_d;
      cnt_q <= cnt_d;
      win_q <= win_d;
      en_q <= s.disable_n;
    end
  end
  assign RUN_CUR_O = run_q;
  assign CUR_PCT_O = pct_q;
  assign DECAY_CHOICE_O = fast_q;
  assign DRV_EN_O = en_q;

  // ****************************************
  // serial receiver
  // ****************************************
  stp_rx_st_t rx_st_q, rx_st_d;
  logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_vld_q, rx_vld_d;
  // mid-bit sampling, frame dropped on bad start or stop bit
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q + 1'b1;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_vld_d = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        rx_cnt_d = '0;
        if (!s.rxd) rx_st_d = RX_START;
      end
      RX_START: begin
        if (rx_cnt_q == CNT_W'(BIT_CYC / 2 - 1)) begin
          rx_cnt_d = '0;
          rx_bit_d = '0;
          rx_st_d = s.rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_cnt_q == CNT_W'(BIT_CYC - 1)) begin
          rx_cnt_d = '0;
          rx_sh_d = {s.rxd, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 1'b1;
          if (rx_bit_q == 3'h7) rx_st_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_cnt_q == CNT_W'(BIT_CYC - 1)) begin
          rx_vld_d = s.rxd;
          rx_st_d = RX_IDLE;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_vld_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_vld_q <= rx_vld_d;
    end
  end

  // ****************************************
  // command parser and parameter store
  // ****************************************
  stp_cmd_st_t cmd_st_q, cmd_st_d;
  logic [7:0] cmd_q, cmd_d, ex_cmd, tx_byte_q, tx_byte_d;
  logic [2:0] left_q, left_d;
  logic [31:0] pay_q, pay_d;
  logic load_q, nv_wr_q, nv_wr_d, tx_req_q, tx_req_d, do_ex;
  // command byte then big-endian payload; known commands answered by their echo, unknown bytes by NAK_BYTE
  always_comb begin
    cmd_st_d = cmd_st_q;
    cmd_d = cmd_q;
    left_d = left_q;
    pay_d = pay_q;
    params_d = params_q;
    nv_wr_d = 1'b0;
    tx_req_d = 1'b0;
    tx_byte_d = tx_byte_q;
    do_ex = 1'b0;
    ex_cmd = cmd_q;
    if (load_q) begin
      params_d = NV_DATA_I;
    end else if (rx_vld_q) begin
      case (cmd_st_q)
        CMD_WAIT: begin
          cmd_d = rx_sh_q;
          ex_cmd = rx_sh_q;
          left_d = cmd_len(rx_sh_q);
          if (left_d == LEN_BAD) begin
            tx_req_d = 1'b1;
            tx_byte_d = NAK_BYTE;
          end else if (left_d == LEN_NONE) do_ex = 1'b1;
          else cmd_st_d = CMD_PAY;
        end
        CMD_PAY: begin
          pay_d = {pay_q[23:0], rx_sh_q};
          left_d = left_q - 1'b1;
          if (left_q == 3'h1) begin
            do_ex = 1'b1;
            cmd_st_d = CMD_WAIT;
          end
        end
        default: cmd_st_d = CMD_WAIT;
      endcase
    end
    if (do_ex) begin
      tx_req_d = 1'b1;
      tx_byte_d = ex_cmd;
      case (ex_cmd)
        CMD_JOG: begin
          params_d.jog_slow = pay_d[31:16];
          params_d.jog_fast = pay_d[15:0];
        end
        CMD_ACCEL: params_d.accel = pay_d[15:0];
        CMD_DECAY: params_d.decay_thr = pay_d[15:0];
        CMD_STORE: nv_wr_d = 1'b1;
        CMD_CLEAR: params_d = PARAMS_DEFAULT;
        default: tx_byte_d = NAK_BYTE;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cmd_st_q <= CMD_WAIT;
      cmd_q <= '0;
      left_q <= '0;
      pay_q <= '0;
      params_q <= PARAMS_DEFAULT;
      load_q <= 1'b1;
      nv_wr_q <= 1'b0;
      tx_req_q <= 1'b0;
      tx_byte_q <= '0;
    end else begin
      cmd_st_q <= cmd_st_d;
      cmd_q <= cmd_d;
      left_q <= left_d;
      pay_q <= pay_d;
      params_q <= params_d;
      load_q <= 1'b0;
      nv_wr_q <= nv_wr_d;
      tx_req_q <= tx_req_d;
      tx_byte_q <= tx_byte_d;
    end
  end
  assign NV_WR_O = nv_wr_q;
  assign NV_DATA_O = params_q;

  // ****************************************
  // serial transmitter
  // ****************************************
  stp_tx_st_t tx_st_q, tx_st_d;
  logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  // one answer byte at a time; a request while busy is dropped
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = '0;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    case (tx_st_q)
      TX_IDLE: begin
        tx_sh_d = '1;
        if (tx_req_q) begin
          tx_sh_d = {1'b1, tx_byte_q, 1'b0};
          tx_bit_d = '0;
          tx_st_d = TX_SEND;
        end
      end
      TX_SEND: begin
        tx_cnt_d = tx_cnt_q + 1'b1;
        if (tx_cnt_q == CNT_W'(BIT_CYC - 1)) begin
          tx_cnt_d = '0;
          tx_sh_d = {1'b1, tx_sh_q[9:1]};
          tx_bit_d = tx_bit_q + 1'b1;
          if (tx_bit_q == 4'h9) tx_st_d = TX_IDLE;
        end
      end
      default: tx_st_d = TX_IDLE;
    endcase
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
    end
  end
  assign TXD_O = tx_sh_q[0];

  // ****************************************
  // assertions
  // ****************************************
  property p_drv_off;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) !s.disable_n |=> !DRV_EN_O;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on while disabled");
  property p_lim_ccw;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) s.lim_ccw && step_fire |-> fire_cw;
  endproperty
  a_lim_ccw: assert property (p_lim_ccw) else $error("ccw step past ccw limit");
  property p_lim_cw;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) s.lim_cw && step_fire |-> !fire_cw;
  endproperty
  a_lim_cw: assert property (p_lim_cw) else $error("cw step past cw limit");
  property p_hold_boot;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(RST_N_I) ##0 !step_fire [*2] |-> !RUN_CUR_O;
  endproperty
  a_hold_boot: assert property (p_hold_boot) else $error("run current before step");
  property p_run_up;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) step_fire |=> RUN_CUR_O && CUR_PCT_O == RUN_PCT;
  endproperty
  a_run_up: assert property (p_run_up) else $error("no run current after step");
  property p_hold_down;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      run_q && idle_q == CNT_W'(HOLD_CYC - 1) && !step_fire |=>
        !RUN_CUR_O && CUR_PCT_O == hold_pct($past(STANDSTILL_CURRENT_SELECT_I));
  endproperty
  a_hold_down: assert property (p_hold_down) else $error("hold level not reached");
  property p_ramp;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $past(params_q.accel) != '0 && !$past(load_q) |->
        (rate_q >= $past(rate_q) ? rate_q - $past(rate_q) : $past(rate_q) - rate_q)
          <= $past(params_q.accel);
  endproperty
  a_ramp: assert property (p_ramp) else $error("jog rate jumped");
  property p_pos;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      step_fire |=> POS_O == ($past(fire_cw) ? $past(pos_q) + $past(inc)
                                             : $past(pos_q) - $past(inc)) && STEP_O;
  endproperty
  a_pos: assert property (p_pos) else $error("position not advanced one step");
  property p_quad;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ENC_MODE_I && (s.step != a_prev_q) && (s.dir == b_prev_q) && !s.lim_cw && !s.lim_ccw
        |-> step_fire && fire_cw == (a_prev_q ^ s.dir);
  endproperty
  a_quad: assert property (p_quad) else $error("quadrature edge lost");
endmodule

//--- dv/stp_ctrl_host.sv
`timescale 1ns/100ps
module stp_ctrl_host (
  input wire logic clk_i, // system clock
  output logic step_o, // step clock to the driver
  output logic dir_o // direction, high cw
);
  realtime last = -1e9;
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
  end
  // one step: keep rate spacing, settle direction, then one pulse
  task automatic step_pulse(input logic d);
    while ($realtime - last < 25000.0) @(negedge clk_i);
    dir_o = d;
    repeat (4) @(negedge clk_i);
    step_o = 1'b1;
    last = $realtime;
    repeat (5) @(negedge clk_i);
    step_o = 1'b0;
  endtask
  // quadrature burst, one channel changing every fourth cycle; order 00,01,11,10 is cw
  task automatic quad(input int edges, input logic cw);
    repeat (edges) begin
      repeat (4) @(negedge clk_i);
      if ((step_o ^ dir_o) == cw) step_o = ~step_o;
      else dir_o = ~dir_o;
    end
  endtask
endmodule

//--- dv/stp_ctrl_tb_top.sv
`timescale 1ns/100ps
module stp_ctrl_tb_top;
  import stp_pkg::*;
  logic clk = 0, rst_n = 0, jccw = 0, jcw = 0, jrs = 0, lccw = 0, lcw = 0, dis_n = 1, d;
  logic enc = 0, rxd = 1, seen;
  logic [1:0] ms = 0, hs = 0;
  logic stp, dr, step_o, dir_o, run, dec, drv, txd, nvwr;
  logic [POS_W-1:0] pos, pexp;
  logic [PCT_W-1:0] pct;
  stp_params_t nvo;
  stp_params_t nvi = '{16'h07D0, 16'h9C40, 16'h9C40, 16'h0000};
  int miscompares = 0, check_count = 0, n = 0, nw = 0;
  // ****************************************
  // clock, partner and design
  // ****************************************
  initial forever #10 clk = ~clk;
  always @(posedge step_o) n++;
  always @(posedge nvwr) nw++;
  stp_ctrl_host u_host (.clk_i(clk), .step_o(stp), .dir_o(dr));
  stp_ctrl #(.HOLD_CYC(200), .TICK_CYC(20), .WIN_CYC(100), .BIT_CYC(16)) u_dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .STEP_I(stp), .DIR_I(dr), .ENC_MODE_I(enc),
    .JOG_CCW_I(jccw), .JOG_CW_I(jcw), .JOG_RATE_SELECT_I(jrs), .LIM_CCW_I(lccw),
    .LIM_CW_I(lcw), .DISABLE_N_I(dis_n), .MICROSTEP_SELECT_I(ms),
    .STANDSTILL_CURRENT_SELECT_I(hs), .RXD_I(rxd), .NV_DATA_I(nvi), .STEP_O(step_o),
    .DIR_O(dir_o), .POS_O(pos), .RUN_CUR_O(run), .CUR_PCT_O(pct), .DECAY_CHOICE_O(dec),
    .DRV_EN_O(drv), .TXD_O(txd), .NV_WR_O(nvwr), .NV_DATA_O(nvo));
  // ****************************************
  // checking helpers
  // ****************************************
  // standstill percentage per select code
  function automatic logic [PCT_W-1:0] hold_exp(input logic [1:0] s);
    logic [PCT_W-1:0] t [4] = '{7'h00, 7'h0F, 7'h32, 7'h64};
    return t[s];
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one 8n1 frame at 16 cycles a bit, lsb first
  task automatic ser_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int j = 0; j < 10; j++) begin
      rxd = f[j];
      repeat (16) @(negedge clk);
    end
  endtask
  // command then big-endian payload; the echo starts two cycles after the stop sample
  task automatic ser_cmd(input logic [7:0] c, input logic [31:0] pay, input int nb,
                         input logic [7:0] e);
    logic [9:0] echo;
    ser_byte(c);
    for (int j = nb - 1; j >= 0; j--) ser_byte(pay[8*j +: 8]);
    repeat (4) @(negedge clk);
    for (int j = 0; j < 10; j++) begin
      echo[j] = txd;
      repeat (16) @(negedge clk);
    end
    chk(echo, {1'b1, e, 1'b0});
  endtask
  // watchdog at about 1.3 times the expected run
  initial begin
    #2ms;
    miscompares++;
    tally_and_finish();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h36d24fe7));
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (5) @(negedge clk);
    chk(nvo, nvi);
    chk(pct, hold_exp(hs));
    chk(drv, 1);
    dis_n = 0;
    repeat (5) @(negedge clk);
    chk(drv, 0);
    dis_n = 1;
    pexp = 0;
    // random steps, limits on every few, each resolution and hold code
    for (int i = 0; i < 24; i++) begin
      ms = $urandom;
      hs = $urandom;
      d = $urandom;
      lccw = (i % 6 == 4);
      lcw = (i % 6 == 5);
      u_host.step_pulse(d);
      if (!((d && lcw) || (!d && lccw))) begin
        pexp = d ? pexp + (5'h08 >> ms) : pexp - (5'h08 >> ms);
        chk(step_o, 1);
        chk(dir_o, d);
        chk(run, 1);
        chk(pct, 7'h64);
      end
      chk(pos, pexp);
      repeat (700) @(negedge clk);
      chk(run, 0);
      chk(pct, hold_exp(hs));
    end
    // serial: unknown byte, clear, program jog, ramp and decay, then store
    ser_cmd(8'h41, '0, 0, 8'h3F);
    ser_cmd(CMD_CLEAR, '0, 0, CMD_CLEAR);
    chk(nvo, PARAMS_DEFAULT);
    ser_cmd(CMD_JOG, 32'h2710_9C40, 4, CMD_JOG);
    ser_cmd(CMD_ACCEL, 32'h0000_0FA0, 2, CMD_ACCEL);
    ser_cmd(CMD_DECAY, 32'h0000_0002, 2, CMD_DECAY);
    chk(nvo, {16'h2710, 16'h9C40, 16'h0FA0, 16'h0002});
    ser_cmd(CMD_STORE, '0, 0, CMD_STORE);
    chk(nw, 1);
    // encoder following: a cw burst dense enough for fast decay, then a ccw burst
    lccw = 0;
    lcw = 0;
    enc = 1;
    u_host.quad(8, 1);
    repeat (8) pexp = pexp + (5'h08 >> ms);
    seen = 0;
    repeat (150) begin
      @(negedge clk);
      seen |= dec;
    end
    chk(seen, 1);
    chk(pos, pexp);
    chk(dir_o, 1);
    u_host.quad(4, 0);
    repeat (4) pexp = pexp - (5'h08 >> ms);
    repeat (250) @(negedge clk);
    chk(pos, pexp);
    chk(dir_o, 0);
    chk(dec, 0);
    enc = 0;
    // jog both ways at both rates, then into each limit
    for (int k = 0; k < 6; k++) begin
      jrs = k[0];
      lcw = (k == 4);
      lccw = (k == 5);
      jccw = k[1] || k == 5;
      jcw = !jccw;
      n = 0;
      repeat (6000) @(negedge clk);
      jcw = 0;
      jccw = 0;
      if (k < 4) chk(dir_o, !k[1]);
      chk(n >= 3, jrs && k < 4);
      chk(n <= 1, !jrs || k >= 4);
      repeat (1000) @(negedge clk);
    end
    tally_and_finish();
  end
endmodule
